// ==== rtl/lmsp_defines.svh ====
// constants of the led matrix spi register port, both ends
// assumes inclusion by bare name from the rtl folder
`ifndef LMSP_DEFINES_SVH
`define LMSP_DEFINES_SVH

// command byte layout
`define LMSP_RW_BIT 7
`define LMSP_ID_HI 6
`define LMSP_ID_LO 4
`define LMSP_PAGE_HI 3
`define LMSP_PAGE_LO 0
`define LMSP_DIR_WRITE 1'b0
`define LMSP_DIR_READ 1'b1
// chip identity code: value is arbitrary
`define LMSP_CHIP_ID 3'h3

// page numbers
`define LMSP_PAGE_PWM 4'h0
`define LMSP_PAGE_SCALE 4'h1
`define LMSP_PAGE_FUNC 4'h2

// byte framing
`define LMSP_BYTE_W 8
`define LMSP_BIT_FIRST 3'h0
`define LMSP_BIT_LAST 3'h7
`define LMSP_NO_CMD 2'h0
`define LMSP_NO_ADDR 2'h1
`define LMSP_NO_DATA 2'h2
`define LMSP_READ_FILL 8'h00

// clocking of the controller end
`define LMSP_CLK_KHZ 100000
`define LMSP_SCK_MAX_KHZ 12000

// transmit buffer
`define LMSP_FIFO_DEPTH 16

`endif

// ==== rtl/lmsp_pkg.sv ====
// types shared by both ends of the led matrix spi register port
// assumes lmsp_defines.svh is compiled alongside
package lmsp_pkg;

    // device byte phase within a frame, gray along the usual path
    typedef enum logic [1:0] {
        LMSP_PH_CMD = 2'h0,
        LMSP_PH_ADDR = 2'h1,
        LMSP_PH_DATA = 2'h3,
        LMSP_PH_SKIP = 2'h2
    } lmsp_phase_t;

    // controller sequencer, gray from idle through lead, shift and load
    typedef enum logic [2:0] {
        LMSP_ST_IDLE = 3'h0,
        LMSP_ST_LEAD = 3'h1,
        LMSP_ST_SHIFT = 3'h3,
        LMSP_ST_LOAD = 3'h2,
        LMSP_ST_TAIL = 3'h6
    } lmsp_state_t;

endpackage

// ==== rtl/lmsp_link_if.sv ====
// the four spi wires plus shutdown between controller and device
// assumes a pull-up on the data output line while nobody drives it
`timescale 1ns/1ps
interface lmsp_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic shutdown_n;
    logic miso;
    logic miso_oe;
    logic miso_wire;

    // resolved line level, released line reads high
    assign miso_wire = miso_oe ? miso : 1'b1;

    modport dev (
        input cs_n,
        input sck,
        input mosi,
        input shutdown_n,
        output miso,
        output miso_oe
    );

    modport ctl (
        output cs_n,
        output sck,
        output mosi,
        output shutdown_n,
        input miso_wire
    );
endinterface

// ==== rtl/lmsp_fifo.sv ====
// byte buffer with valid/ready on both sides, single clock
// assumes both sides run on clk_in
`timescale 1ns/1ps
`include "lmsp_defines.svh"
module lmsp_fifo #(
    parameter int WIDTH = `LMSP_BYTE_W,
    parameter int DEPTH = `LMSP_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic full_reg;
    logic empty_reg;
    logic push;
    logic pop;

    assign push = in_valid_in & ~full_reg;
    assign pop = out_ready_in & ~empty_reg;
    assign count_next = count_reg + CW'(push) - CW'(pop);
    assign in_ready_out = ~full_reg;
    assign out_valid_out = ~empty_reg;
    assign out_data_out = mem[rd_ptr_reg];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
        end
    end

    // flags kept as flops so the ready seen outside is registered
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_reg <= '0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            count_reg <= count_next;
            full_reg <= count_next == CW'(DEPTH);
            empty_reg <= count_next == '0;
        end
    end
endmodule

// ==== rtl/lmsp_host.sv ====
// spi controller end: frames command, address and data bytes
// assumes transmit bytes are pushed before or during a write frame
`timescale 1ns/1ps
`include "lmsp_defines.svh"
module lmsp_host (
    input wire logic clk_in,
    input wire logic rst_n_in,
    lmsp_link_if.ctl link,
    input wire logic start_in,
    input wire logic rw_in,
    input wire logic [3:0] page_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] len_in,
    input wire logic sleep_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic busy_out
);
    // half period rounded up keeps sck at or under its ceiling
    localparam int HALF = (`LMSP_CLK_KHZ + 2 * `LMSP_SCK_MAX_KHZ - 1)
        / (2 * `LMSP_SCK_MAX_KHZ);
    localparam logic [2:0] HALF_M1 = 3'(HALF - 1);

    function automatic logic [7:0] cmd_byte(input logic rw,
                                            input logic [3:0] page);
        cmd_byte = {rw, `LMSP_CHIP_ID, page};
    endfunction

    lmsp_pkg::lmsp_state_t state_reg;
    logic [2:0] div_reg;
    logic sck_reg;
    logic cs_n_reg;
    logic mosi_reg;
    logic sd_n_reg;
    logic [6:0] tx_sh_reg;
    logic [7:0] rx_sh_reg;
    logic [2:0] bit_reg;
    logic [1:0] byte_no_reg;
    logic [7:0] left_reg;
    logic rw_reg;
    logic [7:0] addr_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic busy_reg;
    logic miso_s1_reg;
    logic miso_s2_reg;
    logic tick;
    logic fifo_pop;
    logic fifo_valid;
    logic [7:0] fifo_data;

    assign tick = div_reg == HALF_M1;
    assign fifo_pop = state_reg == lmsp_pkg::LMSP_ST_LOAD;
    assign link.cs_n = cs_n_reg;
    assign link.sck = sck_reg;
    assign link.mosi = mosi_reg;
    assign link.shutdown_n = sd_n_reg;
    assign rd_data_out = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;
    assign busy_out = busy_reg;

    lmsp_fifo #(
        .WIDTH(`LMSP_BYTE_W),
        .DEPTH(`LMSP_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_data_in(tx_data_in),
        .in_valid_in(tx_valid_in),
        .in_ready_out(tx_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////
    // pin sampling and shutdown drive

    always_ff @(posedge clk_in) begin
        miso_s1_reg <= link.miso_wire;
        miso_s2_reg <= miso_s1_reg;
    end

    // low in reset, so release gives the device a rising edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sd_n_reg <= 1'b0;
        end else begin
            sd_n_reg <= ~sleep_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_reg == lmsp_pkg::LMSP_ST_IDLE ||
            state_reg == lmsp_pkg::LMSP_ST_LOAD || tick) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame sequencer

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= lmsp_pkg::LMSP_ST_IDLE;
            cs_n_reg <= 1'b1;
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
            tx_sh_reg <= 7'h00;
            rx_sh_reg <= 8'h00;
            bit_reg <= `LMSP_BIT_FIRST;
            byte_no_reg <= `LMSP_NO_CMD;
            left_reg <= 8'h00;
            rw_reg <= `LMSP_DIR_WRITE;
            addr_reg <= 8'h00;
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            rd_valid_reg <= 1'b0;
            unique case (state_reg)
                lmsp_pkg::LMSP_ST_IDLE: begin
                    if (start_in) begin
                        // command byte first, msb first
                        {mosi_reg, tx_sh_reg} <= cmd_byte(rw_in, page_in);
                        rw_reg <= rw_in;
                        addr_reg <= addr_in;
                        left_reg <= len_in;
                        cs_n_reg <= 1'b0;
                        bit_reg <= `LMSP_BIT_FIRST;
                        byte_no_reg <= `LMSP_NO_CMD;
                        busy_reg <= 1'b1;
                        state_reg <= lmsp_pkg::LMSP_ST_LEAD;
                    end
                end
                lmsp_pkg::LMSP_ST_LEAD: begin
                    if (tick) begin
                        state_reg <= lmsp_pkg::LMSP_ST_SHIFT;
                    end
                end
                lmsp_pkg::LMSP_ST_SHIFT: begin
                    if (tick && !sck_reg) begin
                        sck_reg <= 1'b1;
                        rx_sh_reg <= {rx_sh_reg[6:0], miso_s2_reg};
                    end else if (tick) begin
                        sck_reg <= 1'b0;
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg != `LMSP_BIT_LAST) begin
                            {mosi_reg, tx_sh_reg} <= {tx_sh_reg, 1'b0};
                        end else begin
                            if (byte_no_reg == `LMSP_NO_DATA &&
                                rw_reg == `LMSP_DIR_READ) begin
                                rd_data_reg <= rx_sh_reg;
                                rd_valid_reg <= 1'b1;
                            end
                            // address after command, data after address
                            if (byte_no_reg == `LMSP_NO_CMD) begin
                                {mosi_reg, tx_sh_reg} <= addr_reg;
                                byte_no_reg <= `LMSP_NO_ADDR;
                            end else if (left_reg == 8'h00) begin
                                state_reg <= lmsp_pkg::LMSP_ST_TAIL;
                            end else if (rw_reg == `LMSP_DIR_WRITE) begin
                                state_reg <= lmsp_pkg::LMSP_ST_LOAD;
                            end else begin
                                {mosi_reg, tx_sh_reg} <= `LMSP_READ_FILL;
                                left_reg <= left_reg - 8'h01;
                                byte_no_reg <= `LMSP_NO_DATA;
                            end
                        end
                    end
                end
                lmsp_pkg::LMSP_ST_LOAD: begin
                    // sck stalls low while the buffer is empty
                    if (fifo_valid) begin
                        {mosi_reg, tx_sh_reg} <= fifo_data;
                        left_reg <= left_reg - 8'h01;
                        byte_no_reg <= `LMSP_NO_DATA;
                        state_reg <= lmsp_pkg::LMSP_ST_SHIFT;
                    end
                end
                lmsp_pkg::LMSP_ST_TAIL: begin
                    if (tick) begin
                        cs_n_reg <= 1'b1;
                        busy_reg <= 1'b0;
                        state_reg <= lmsp_pkg::LMSP_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= lmsp_pkg::LMSP_ST_IDLE;
                    cs_n_reg <= 1'b1;
                end
            endcase
        end
    end
endmodule

// ==== rtl/lmsp_device.sv ====
// spi target end of the led matrix driver register port
// assumes the controller makes sck and holds it still outside frames;
// the paged register space is held here, user side sees each access
`timescale 1ns/1ps
`include "lmsp_defines.svh"
module lmsp_device (
    input wire logic clk_in,
    input wire logic rst_n_in,
    lmsp_link_if.dev link,
    output logic acc_valid_out,
    output logic acc_read_out,
    output logic [3:0] acc_page_out,
    output logic [7:0] acc_addr_out,
    output logic [7:0] acc_data_out
);
    localparam int EW = 1 + 4 + 8 + 8;

    // pages 0..2 share one array, page in the top index bits
    function automatic logic [9:0] mem_index(input logic [3:0] page,
                                             input logic [7:0] addr);
        mem_index = {page[1:0], addr};
    endfunction

    function automatic logic page_ok(input logic [3:0] page);
        page_ok = page == `LMSP_PAGE_PWM || page == `LMSP_PAGE_SCALE ||
            page == `LMSP_PAGE_FUNC;
    endfunction

    logic [7:0] mem [0:767];
    logic frame_rst;
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_sh_reg;
    logic [7:0] rx_byte;
    logic byte_done;
    lmsp_pkg::lmsp_phase_t phase_reg;
    logic rw_reg;
    logic [3:0] page_reg;
    logic [7:0] addr_reg;
    logic [7:0] rd_byte;
    logic in_data;
    logic wr_fire;
    logic rd_fire;
    logic [6:0] tx_sh_reg;
    logic miso_reg;
    logic oe_reg;
    logic ev_tgl_reg;
    logic [EW-1:0] ev_hold_reg;
    logic ev_s1_reg;
    logic ev_s2_reg;
    logic ev_s3_reg;
    logic acc_valid_reg;
    logic [EW-1:0] acc_reg;

    // frame logic is held idle while deselected or shut down, so
    // a partial byte simply vanishes; sck may stop outside frames
    assign frame_rst = link.cs_n | ~link.shutdown_n;
    assign rx_byte = {rx_sh_reg, link.mosi};
    assign byte_done = bit_cnt_reg == `LMSP_BIT_LAST;
    assign rd_byte = mem[mem_index(page_reg, addr_reg)];
    assign in_data = phase_reg == lmsp_pkg::LMSP_PH_DATA;
    assign wr_fire = byte_done && in_data && rw_reg == `LMSP_DIR_WRITE;
    assign rd_fire = byte_done && in_data && rw_reg == `LMSP_DIR_READ;
    assign link.miso = miso_reg;
    assign link.miso_oe = oe_reg;

    ////////////////////////////////////////////////////////////////////
    // receive side, rising sck

    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_reg <= `LMSP_BIT_FIRST;
            rx_sh_reg <= 7'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_sh_reg <= rx_byte[6:0];
        end
    end

    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            phase_reg <= lmsp_pkg::LMSP_PH_CMD;
            rw_reg <= `LMSP_DIR_WRITE;
            page_reg <= `LMSP_PAGE_PWM;
        end else if (byte_done) begin
            unique case (phase_reg)
                lmsp_pkg::LMSP_PH_CMD: begin
                    rw_reg <= rx_byte[`LMSP_RW_BIT];
                    page_reg <= rx_byte[`LMSP_PAGE_HI:`LMSP_PAGE_LO];
                    // foreign identity or unknown page: ignore frame
                    if (rx_byte[`LMSP_ID_HI:`LMSP_ID_LO] == `LMSP_CHIP_ID &&
                        page_ok(rx_byte[`LMSP_PAGE_HI:`LMSP_PAGE_LO])) begin
                        phase_reg <= lmsp_pkg::LMSP_PH_ADDR;
                    end else begin
                        phase_reg <= lmsp_pkg::LMSP_PH_SKIP;
                    end
                end
                lmsp_pkg::LMSP_PH_ADDR: begin
                    phase_reg <= lmsp_pkg::LMSP_PH_DATA;
                end
                lmsp_pkg::LMSP_PH_DATA: begin
                    phase_reg <= lmsp_pkg::LMSP_PH_DATA;
                end
                lmsp_pkg::LMSP_PH_SKIP: begin
                    phase_reg <= lmsp_pkg::LMSP_PH_SKIP;
                end
            endcase
        end
    end

    // address wraps within the page after 0xFF
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            addr_reg <= 8'h00;
        end else if (byte_done &&
                     phase_reg == lmsp_pkg::LMSP_PH_ADDR) begin
            addr_reg <= rx_byte;
        end else if (byte_done && in_data) begin
            addr_reg <= addr_reg + 8'h01;
        end
    end

    // only whole bytes land here, partial ones never reach byte_done
    always_ff @(posedge link.sck) begin
        if (wr_fire) begin
            mem[mem_index(page_reg, addr_reg)] <= rx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit side, falling sck

    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            tx_sh_reg <= 7'h00;
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else if (in_data && rw_reg == `LMSP_DIR_READ) begin
            oe_reg <= 1'b1;
            if (bit_cnt_reg == `LMSP_BIT_FIRST) begin
                // load on the fall after the address or the 8th edge
                {miso_reg, tx_sh_reg} <= rd_byte;
            end else begin
                {miso_reg, tx_sh_reg} <= {tx_sh_reg, 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // access reports to clk_in by toggle; hold is stable for a byte
    // time (800 ns at the bench rate), far above the sync latency

    always_ff @(posedge link.sck or negedge link.shutdown_n) begin
        if (!link.shutdown_n) begin
            ev_tgl_reg <= 1'b0;
            ev_hold_reg <= '0;
        end else if (wr_fire) begin
            ev_hold_reg <= {`LMSP_DIR_WRITE, page_reg, addr_reg, rx_byte};
            ev_tgl_reg <= ~ev_tgl_reg;
        end else if (rd_fire) begin
            ev_hold_reg <= {`LMSP_DIR_READ, page_reg, addr_reg, rd_byte};
            ev_tgl_reg <= ~ev_tgl_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ev_s1_reg <= 1'b0;
            ev_s2_reg <= 1'b0;
            ev_s3_reg <= 1'b0;
        end else begin
            ev_s1_reg <= ev_tgl_reg;
            ev_s2_reg <= ev_s1_reg;
            ev_s3_reg <= ev_s2_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            acc_valid_reg <= 1'b0;
            acc_reg <= '0;
        end else begin
            acc_valid_reg <= ev_s2_reg ^ ev_s3_reg;
            if (ev_s2_reg ^ ev_s3_reg) begin
                acc_reg <= ev_hold_reg;
            end
        end
    end

    assign acc_valid_out = acc_valid_reg;
    assign acc_read_out = acc_reg[EW-1];
    assign acc_page_out = acc_reg[EW-2:EW-5];
    assign acc_addr_out = acc_reg[15:8];
    assign acc_data_out = acc_reg[7:0];
endmodule

// ==== bench/lmsp_link_monitor.sv ====
// wire-level checks on the link joining the two design ends
// assumes sck is made by the controller end from clk_in
`timescale 1ns/1ps
`include "lmsp_defines.svh"
module lmsp_link_monitor (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic shutdown_n,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic miso_wire
);
    logic sck_reg;
    logic [11:0] rise_cnt_reg;
    logic [7:0] cmd_reg;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        sck_reg <= sck;
    end
    // 12 bits: longest frame is 257 bytes of rises
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || cs_n) begin
            rise_cnt_reg <= 12'h000;
        end else if (sck && !sck_reg) begin
            rise_cnt_reg <= rise_cnt_reg + 12'h001;
        end
    end
    always_ff @(posedge clk_in) begin
        if (sck && !sck_reg && rise_cnt_reg < 12'h008) begin
            cmd_reg <= {cmd_reg[6:0], mosi};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_select_lead_time: assert property (
        $fell(cs_n) |-> (!sck) [*5] ##1 (!sck) [*5] ##1 sck)
        else $error("sck rose at the wrong time after select");
    a_sck_half_period: assert property (
        $changed(sck) |=> $stable(sck) [*4])
        else $error("sck half period too short");
    a_mosi_steady_high: assert property (
        sck |-> $stable(mosi))
        else $error("mosi moved while sck high");
    a_whole_bytes: assert property (
        $rose(cs_n) |-> rise_cnt_reg[2:0] == 3'h0
            && rise_cnt_reg >= 12'h010)
        else $error("frame not made of whole bytes");
    a_cmd_identity: assert property (
        rise_cnt_reg == 12'h008 && $changed(rise_cnt_reg)
            |-> cmd_reg[6:4] == `LMSP_CHIP_ID)
        else $error("command identity field wrong");
    a_release_idle: assert property (
        cs_n && $past(cs_n) |-> !miso_oe && miso_wire)
        else $error("miso driven while deselected");
    a_shutdown_quiet: assert property (
        !shutdown_n |-> !miso_oe)
        else $error("miso driven in shutdown");
    a_read_drive_start: assert property (
        $rose(miso_oe) |-> rise_cnt_reg == 12'h010 && !sck)
        else $error("read data began at wrong bit");
endmodule

// ==== bench/lmsp_tb.sv ====
// self-checking bench: controller end against device end
// assumes the design files of rtl are compiled first
`timescale 1ns/1ps
`include "lmsp_defines.svh"
module lmsp_tb;
    logic clk_in, rst_n_in, start_in, rw_in, sleep_in, tx_valid_in;
    logic [3:0] page_in;
    logic [7:0] addr_in, len_in, tx_data_in, rd_data_out, d2, a2;
    logic tx_ready_out, rd_valid_out, busy_out, v2;
    logic acc_valid_out, acc_read_out;
    logic [3:0] acc_page_out;
    logic [7:0] acc_addr_out, acc_data_out;
    logic [7:0] mem [0:2][0:255];
    logic [20:0] exp_q[$];
    logic [7:0] rd_q[$], bq[$];
    int err_total, n_compared, n2, cyc;
    lmsp_link_if link_i ();
    lmsp_link_if link2_i ();
    lmsp_host lmsp_host_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .link(link_i), .start_in(start_in), .rw_in(rw_in),
        .page_in(page_in), .addr_in(addr_in), .len_in(len_in),
        .sleep_in(sleep_in), .tx_data_in(tx_data_in),
        .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .busy_out(busy_out));
    lmsp_device lmsp_device_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .link(link_i), .acc_valid_out(acc_valid_out),
        .acc_read_out(acc_read_out), .acc_page_out(acc_page_out),
        .acc_addr_out(acc_addr_out), .acc_data_out(acc_data_out));
    // second device faces a bench driver that breaks framing on purpose
    lmsp_device lmsp_device_2_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .link(link2_i), .acc_valid_out(v2), .acc_read_out(),
        .acc_page_out(), .acc_addr_out(a2), .acc_data_out(d2));
    lmsp_link_monitor lmsp_link_monitor_i (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .cs_n(link_i.cs_n), .sck(link_i.sck),
        .mosi(link_i.mosi), .shutdown_n(link_i.shutdown_n),
        .miso(link_i.miso), .miso_oe(link_i.miso_oe),
        .miso_wire(link_i.miso_wire));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wait_busy(input logic v);
        int k;
        k = 0;
        while (busy_out !== v && k < 9000) begin
            @(negedge clk_in);
            k++;
        end
        if (k == 9000) err_total++;
    endtask
    task automatic run(input logic r, input logic [3:0] pg,
                       input logic [7:0] ad, input logic [7:0] ln);
        @(negedge clk_in);
        rw_in = r;
        page_in = pg;
        addr_in = ad;
        len_in = ln;
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (8) @(negedge clk_in);
        chk(exp_q.size(), 0);
        chk(rd_q.size(), 0);
    endtask
    // valid held across pushes; lowered once at the end
    task automatic feed();
        int k;
        while (bq.size() > 0) begin
            tx_data_in = bq.pop_front();
            tx_valid_in = 1'b1;
            k = 0;
            while (tx_ready_out !== 1'b1 && k < 9000) begin
                @(negedge clk_in);
                k++;
            end
            @(negedge clk_in);
        end
        tx_valid_in = 1'b0;
    endtask
    task automatic wr(input logic [3:0] pg, input logic [7:0] ad,
                      input logic [7:0] ln, input bit late);
        logic [7:0] d;
        for (int i = 0; i < ln; i++) begin
            d = $urandom;
            mem[pg][8'(ad + i)] = d;
            exp_q.push_back({1'b0, pg, 8'(ad + i), d});
            bq.push_back(d);
        end
        if (late) begin
            fork
                run(1'b0, pg, ad, ln);
                begin
                    repeat (200) @(negedge clk_in);
                    feed();
                end
            join
        end else begin
            feed();
            @(negedge clk_in);
            chk(tx_ready_out, ln != 8'h10);
            run(1'b0, pg, ad, ln);
        end
    endtask
    task automatic rd(input logic [3:0] pg, input logic [7:0] ad,
                      input logic [7:0] ln);
        logic [7:0] a;
        for (int i = 0; i < ln; i++) begin
            a = 8'(ad + i);
            if (pg < 4'h3) begin
                exp_q.push_back({1'b1, pg, a, mem[pg][a]});
                rd_q.push_back(mem[pg][a]);
            end else begin
                rd_q.push_back(8'hFF);
            end
        end
        run(1'b1, pg, ad, ln);
    endtask
    task automatic bang(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            link2_i.mosi = b[7 - i];
            repeat (5) @(negedge clk_in);
            link2_i.sck = 1'b1;
            repeat (5) @(negedge clk_in);
            link2_i.sck = 1'b0;
        end
    endtask
    task automatic frame2(input logic [7:0] c, input logic [7:0] d,
                          input int n);
        link2_i.cs_n = 1'b0;
        repeat (5) @(negedge clk_in);
        bang(c, 8);
        bang(8'h10, 8);
        bang(d, n);
        repeat (5) @(negedge clk_in);
        link2_i.cs_n = 1'b1;
        repeat (20) @(negedge clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(negedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            summarize();
        end
        if (acc_valid_out === 1'b1) begin
            chk({acc_read_out, acc_page_out, acc_addr_out, acc_data_out},
                exp_q.size() ? exp_q.pop_front() : 21'h1FFFFF);
        end
        if (rd_valid_out === 1'b1) begin
            chk(rd_data_out, rd_q.size() ? rd_q.pop_front() : 8'h5A);
        end
        if (v2 === 1'b1) n2++;
    end
    initial begin
        {rst_n_in, start_in, rw_in, sleep_in, tx_valid_in} = 5'h00;
        {page_in, addr_in, len_in, tx_data_in} = 28'h0000000;
        // time-zero edges may be missed, so reset device 2 by later ones
        {link2_i.cs_n, link2_i.sck, link2_i.mosi} = 3'h0;
        link2_i.shutdown_n = 1'b1;
        @(negedge clk_in);
        {link2_i.cs_n, link2_i.shutdown_n} = 2'h2;
        @(negedge clk_in);
        rst_n_in = 1'b1;
        link2_i.shutdown_n = 1'b1;
        void'($urandom(87992));
        sleep_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk(link_i.shutdown_n, 1'b0);
        sleep_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk(link_i.shutdown_n, 1'b1);
        for (int p = 0; p < 6; p++) begin
            addr_in = $urandom;
            len_in = 8'h01 + 8'($urandom % 4);
            wr(4'(p % 3), addr_in, len_in, p == 4);
            rd(4'(p % 3), addr_in, len_in);
        end
        wr(4'h2, 8'hFE, 8'h03, 1'b0);
        rd(4'h2, 8'hFE, 8'h03);
        wr(4'h1, 8'h20, 8'h00, 1'b0);
        rd(4'h3, 8'h20, 8'h02);
        wr(4'h0, 8'h40, 8'h10, 1'b0);
        rd(4'h0, 8'h40, 8'h10);
        frame2({1'b0, ~`LMSP_CHIP_ID, `LMSP_PAGE_SCALE}, 8'hA5, 8);
        chk(n2, 0);
        frame2({1'b0, `LMSP_CHIP_ID, `LMSP_PAGE_SCALE}, 8'h3C, 4);
        chk(n2, 0);
        frame2({1'b0, `LMSP_CHIP_ID, `LMSP_PAGE_SCALE}, 8'hA5, 8);
        chk(n2, 1);
        chk({a2, d2}, 16'h10A5);
        chk(link2_i.miso_oe, 1'b0);
        summarize();
    end
endmodule
